//--- logic/ecs_pkg.sv
// package of constants and types for the eeprom command sequencer
// Summary of operation
// - erase verify sets blank flag if erased
// - program writes one buffered word
// - sector erase clears four-byte sector
// - mass erase needs disable and open bits
// - sector modify erases then reprograms word
// - program may queue behind sector modify
// - bad array writes set access error
// - out-of-order step after the array write sets access error
// - non-status write after command is error
// - unknown command code sets access error
// - writing zero to buffers flag aborts
// - register reads never disturb sequence
// - array reads during execution give junk
// - access error locks out launches
// - protected target sets violation, locks launches
// - wait mode completes active and pending
// - stop aborts command, sets complete, error
// - debug state relaxes protection; secured debug takes only mass erase
// - reset aborts command in progress
// - interrupt from flag and enable pairs
// - launch clears complete; flags set later
// - no program/erase before divider loaded
package ecs_pkg;
    localparam int ADDR_W = 9;
    localparam int WORDS  = 256;
    // register offsets on the register port
    localparam logic [3:0] OFS_DIV  = 4'h0;
    localparam logic [3:0] OFS_CFG  = 4'h1;
    localparam logic [3:0] OFS_PROT = 4'h2;
    localparam logic [3:0] OFS_STAT = 4'h3;
    localparam logic [3:0] OFS_CMD  = 4'h4;
    // status bit positions
    localparam int ST_BEIF  = 7;
    localparam int ST_DONE  = 6;
    localparam int ST_PROTV = 5;
    localparam int ST_ACC   = 4;
    localparam int ST_BLANK = 2;
    // config bit positions
    localparam int CF_BEIE = 7;
    localparam int CF_DONE_IE = 6;
    // protection bit positions
    localparam int PR_OPEN = 7;
    localparam int PR_DIS  = 3;
    localparam logic [7:0] PROT_RST = 8'h88;
    localparam logic [15:0] ERASED  = 16'hFFFF;
    // command codes
    localparam logic [7:0] CMD_VERIFY = 8'h05;
    localparam logic [7:0] CMD_PROG   = 8'h20;
    localparam logic [7:0] CMD_SECT   = 8'h40;
    localparam logic [7:0] CMD_MASS   = 8'h41;
    localparam logic [7:0] CMD_MODIFY = 8'h60;
    // algorithm step length in cycles, kept short on purpose
    localparam logic [7:0] STEP_CYC = 8'h08;
    typedef struct packed {
        logic [7:0]          cmd;
        logic [ADDR_W-1:0]   addr;
        logic [15:0]         data;
    } ecs_job_t;
    typedef enum logic [4:0] {
        EX_IDLE   = 5'b00001,
        EX_WAIT   = 5'b00010,
        EX_ERASE  = 5'b00100,
        EX_PROG   = 5'b01000,
        EX_VERIFY = 5'b10000
    } ecs_ex_t;
    typedef enum logic [2:0] {
        SQ_EMPTY = 3'b001,
        SQ_WORD  = 3'b010,
        SQ_CMD   = 3'b100
    } ecs_sq_t;
endpackage

//--- logic/ecs_sequencer.sv
// eeprom command sequencer: register port, command buffer and executor
`timescale 1ns/10ps
module ecs_sequencer
    import ecs_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // register port
    input  wire logic [3:0]        regAddr,
    input  wire logic [7:0]        regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic [7:0]             regRdata,
    // array port (word writes and reads)
    input  wire logic [ADDR_W-1:0] arrAddr,
    input  wire logic [15:0]       arrWdata,
    input  wire logic [1:0]        arrByteEn,
    input  wire logic              arrWr,
    input  wire logic              arrRd,
    output logic [15:0]            arrRdata,
    // chip modes
    input  wire logic              stopMode,
    input  wire logic              debugState,
    input  wire logic              chipSecured,
    // status outputs
    output logic                   highVoltageOn,
    output logic                   irqBuffersEmpty,
    output logic                   irqCommandsDone
);
    logic [15:0] memQ [WORDS];
    logic [7:0]  divQ;
    logic        divLoadedQ;
    logic [7:0]  cfgQ;
    logic [7:0]  protQ;
    logic        beifQ, doneQ, protViolQ, accQ, blankQ;
    ecs_sq_t     sqQ;
    ecs_job_t    bufQ, actQ;
    logic        pendQ;
    ecs_ex_t     exQ;
    logic [7:0]  tickQ;
    logic [7:0]  idxQ;
    logic        allErasedQ;
    logic        stopSyncA, stopSync;

    function automatic logic validCmd(input logic [7:0] c);
        return c == CMD_VERIFY || c == CMD_PROG || c == CMD_SECT ||
               c == CMD_MASS || c == CMD_MODIFY;
    endfunction

    // word index in a 256-word space protected from the top down
    function automatic logic isProtected(input logic [ADDR_W-1:0] a);
        logic [7:0] w;
        w = a[ADDR_W-1:1];
        if (protQ[PR_OPEN])
            return 1'b0;
        return w >= 8'(8'hFF - {protQ[2:0], 4'h0});
    endfunction

    logic anyProt;
    assign anyProt = !protQ[PR_OPEN] || !protQ[PR_DIS];

    // stop arrives from outside this clock domain
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stopSyncA <= 1'b0;
            stopSync  <= 1'b0;
        end else begin
            stopSyncA <= stopMode;
            stopSync  <= stopSyncA;
        end
    end
    logic stopPrev;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) stopPrev <= 1'b0;
        else         stopPrev <= stopSync;
    end
    logic stopEnter, stopExit;
    assign stopEnter = stopSync && !stopPrev;
    assign stopExit  = !stopSync && stopPrev;

    // register decode
    logic wrDiv, wrCfg, wrProt, wrStat, wrCmd, wrOther;
    assign wrDiv  = regWr && regAddr == OFS_DIV;
    assign wrCfg  = regWr && regAddr == OFS_CFG;
    assign wrProt = regWr && regAddr == OFS_PROT;
    assign wrStat = regWr && regAddr == OFS_STAT;
    assign wrCmd  = regWr && regAddr == OFS_CMD;
    assign wrOther = regWr && !wrStat && !wrCmd;

    logic locked;
    assign locked = accQ || protViolQ;

    logic launch;
    assign launch = wrStat && regWdata[ST_BEIF] && sqQ == SQ_CMD && !locked;

    // sequence errors; reads never count
    logic badArr, badCmdStep, abortZero, accSet, pvSet;
    assign badArr = arrWr && (!divLoadedQ || arrByteEn != 2'b11 ||
                    arrAddr[0] || !beifQ || sqQ != SQ_EMPTY || locked);
    assign badCmdStep = (sqQ == SQ_WORD && regWr && !wrCmd) ||
                        (sqQ == SQ_CMD && (wrCmd || wrOther)) ||
                        (sqQ == SQ_CMD && wrStat && regWdata[ST_BEIF] &&
                         !divLoadedQ && bufQ.cmd != CMD_VERIFY);
    assign abortZero = wrStat && !regWdata[ST_BEIF] && sqQ != SQ_EMPTY;

    logic cmdOk, cmdProt;
    always_comb begin
        cmdOk = validCmd(regWdata);
        if (debugState && chipSecured)
            cmdOk = regWdata == CMD_MASS;
        cmdProt = 1'b0;
        if (!(debugState && !chipSecured)) begin
            if (regWdata == CMD_MASS)
                cmdProt = anyProt;
            else if (regWdata != CMD_VERIFY)
                cmdProt = isProtected(bufQ.addr);
        end
    end
    assign accSet = badArr || badCmdStep || abortZero ||
                    (sqQ == SQ_WORD && wrCmd && !cmdOk) ||
                    (stopEnter && !doneQ);
    assign pvSet = sqQ == SQ_WORD && wrCmd && cmdOk && cmdProt;

    // sequence state and buffer
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sqQ  <= SQ_EMPTY;
            bufQ <= '0;
        end else if (accSet || pvSet || launch) begin
            sqQ <= SQ_EMPTY;
        end else if (arrWr && sqQ == SQ_EMPTY) begin
            sqQ       <= SQ_WORD;
            bufQ.addr <= arrAddr;
            bufQ.data <= arrWdata;
        end else if (wrCmd && sqQ == SQ_WORD) begin
            sqQ      <= SQ_CMD;
            bufQ.cmd <= regWdata;
        end
    end

    logic exDone, startNext;
    assign startNext = (exQ == EX_IDLE || exDone) && (pendQ || launch);

    // pending slot: second stage of the two-deep pipe
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pendQ <= 1'b0;
        end else if (stopEnter || stopExit) begin
            pendQ <= 1'b0;
        end else if (launch && (exQ != EX_IDLE && !exDone)) begin
            pendQ <= 1'b1;
        end else if (startNext) begin
            pendQ <= 1'b0;
        end
    end

    // status flags
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            beifQ  <= 1'b1;
            doneQ  <= 1'b1;
            accQ   <= 1'b0;
            protViolQ <= 1'b0;
        end else begin
            if (stopExit)
                beifQ <= 1'b1;
            else if (launch && (exQ != EX_IDLE && !exDone) && !pendQ)
                beifQ <= 1'b0;
            else if (!pendQ)
                beifQ <= 1'b1;
            if (launch)
                doneQ <= 1'b0;
            else if (stopEnter && !doneQ)
                doneQ <= 1'b1;
            else if (exDone && !pendQ)
                doneQ <= 1'b1;
            // set wins over a clear in the same cycle
            if (accSet)
                accQ <= 1'b1;
            else if (wrStat && regWdata[ST_ACC])
                accQ <= 1'b0;
            if (pvSet)
                protViolQ <= 1'b1;
            else if (wrStat && regWdata[ST_PROTV])
                protViolQ <= 1'b0;
        end
    end

    // control registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            divQ       <= '0;
            divLoadedQ <= 1'b0;
            cfgQ       <= '0;
            protQ      <= PROT_RST;
        end else begin
            if (wrDiv && sqQ == SQ_EMPTY) begin
                divQ       <= regWdata;
                divLoadedQ <= 1'b1;
            end
            if (wrCfg && sqQ == SQ_EMPTY)
                cfgQ <= regWdata;
            if (wrProt && sqQ == SQ_EMPTY && (debugState || protQ[PR_OPEN]))
                protQ <= regWdata;
        end
    end

    // executor: one-cycle erase/program steps after a timed wait
    ecs_ex_t nextPhase;
    always_comb begin
        unique case (actQ.cmd)
            CMD_VERIFY: nextPhase = EX_VERIFY;
            CMD_PROG:   nextPhase = EX_PROG;
            default:    nextPhase = EX_ERASE;
        endcase
    end
    assign exDone = (exQ == EX_PROG) ||
                    (exQ == EX_ERASE && actQ.cmd != CMD_MODIFY) ||
                    (exQ == EX_VERIFY && idxQ == 8'hFF);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            exQ   <= EX_IDLE;
            actQ  <= '0;
            tickQ <= '0;
        end else if (stopEnter) begin
            exQ <= EX_IDLE;
        end else if (startNext) begin
            actQ  <= bufQ;
            exQ   <= EX_WAIT;
            tickQ <= STEP_CYC;
        end else begin
            unique case (exQ)
                EX_IDLE: ;
                EX_WAIT: begin
                    if (tickQ == 8'h00)
                        exQ <= nextPhase;
                    else
                        tickQ <= tickQ - 8'h01;
                end
                EX_ERASE: begin
                    if (actQ.cmd == CMD_MODIFY) begin
                        exQ   <= EX_WAIT;
                        actQ.cmd <= CMD_PROG;
                        tickQ <= STEP_CYC;
                    end else begin
                        exQ <= EX_IDLE;
                    end
                end
                EX_PROG:   exQ <= EX_IDLE;
                EX_VERIFY: if (exDone) exQ <= EX_IDLE;
                default:   exQ <= EX_IDLE;
            endcase
        end
    end
    assign highVoltageOn = exQ == EX_ERASE || exQ == EX_PROG || exQ == EX_WAIT;

    // verify scan and blank flag
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            idxQ       <= '0;
            allErasedQ <= 1'b1;
            blankQ     <= 1'b0;
        end else begin
            if (launch)
                blankQ <= 1'b0;
            if (exQ != EX_VERIFY) begin
                idxQ       <= '0;
                allErasedQ <= 1'b1;
            end else begin
                idxQ <= idxQ + 8'h01;
                if (memQ[idxQ] != ERASED)
                    allErasedQ <= 1'b0;
                if (exDone)
                    blankQ <= allErasedQ && memQ[idxQ] == ERASED;
            end
        end
    end

    // array contents, no reset: undefined after an aborted command
    logic [7:0] wIdx, sIdx;
    assign wIdx = actQ.addr[ADDR_W-1:1];
    assign sIdx = {wIdx[7:1], 1'b0};
    always_ff @(posedge sys_clk) begin
        if (exQ == EX_PROG) begin
            memQ[wIdx] <= actQ.data;
        end else if (exQ == EX_ERASE) begin
            if (actQ.cmd == CMD_MASS) begin
                for (int i = 0; i < WORDS; i++)
                    memQ[i] <= ERASED;
            end else begin
                memQ[sIdx]         <= ERASED;
                memQ[sIdx + 8'h01] <= ERASED;
            end
        end
    end

    // array reads: junk while a command runs
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst)
            arrRdata <= '0;
        else if (arrRd)
            arrRdata <= doneQ ? memQ[arrAddr[ADDR_W-1:1]] : 16'hDEAD;
    end

    // register reads
    logic [7:0] stat;
    assign stat = {beifQ, doneQ, protViolQ, accQ, 1'b0, blankQ, 2'b00};
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdata <= '0;
        end else if (regRd) begin
            unique case (regAddr)
                OFS_DIV:  regRdata <= {divLoadedQ, divQ[6:0]};
                OFS_CFG:  regRdata <= cfgQ;
                OFS_PROT: regRdata <= protQ;
                OFS_STAT: regRdata <= stat;
                OFS_CMD:  regRdata <= bufQ.cmd;
                default:  regRdata <= '0;
            endcase
        end
    end

    // level requests; the processor applies its own global mask
    // wait mode needs nothing: the executor simply keeps running
    assign irqBuffersEmpty = beifQ && cfgQ[CF_BEIE];
    assign irqCommandsDone = doneQ && cfgQ[CF_DONE_IE];
endmodule

//--- sim/ecs_sequencer_properties.sv
// port-level assertions for the eeprom command sequencer
`timescale 1ns/10ps
module ecs_seq_checker
    import ecs_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    // register port
    input wire logic [3:0]  regAddr,
    input wire logic        regRd,
    input wire logic [7:0]  regRdata,
    // array port
    input wire logic        arrRd,
    input wire logic [15:0] arrRdata,
    // modes and status
    input wire logic        stopMode,
    input wire logic        highVoltageOn,
    input wire logic        irqBuffersEmpty,
    input wire logic        irqCommandsDone
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    a_busy_array_junk: assert property (
        arrRd && highVoltageOn |=> arrRdata == 16'hDEAD)
        else $error("array read while busy not junk");
    // two sync stages plus one state update
    a_stop_hv_off: assert property (
        stopMode [*4] |-> !highVoltageOn)
        else $error("high voltage on in stop");
    a_be_irq_flag: assert property (
        regRd && regAddr == OFS_STAT && irqBuffersEmpty
        |=> regRdata[ST_BEIF])
        else $error("buffers irq without flag");
    a_cc_irq_flag: assert property (
        regRd && regAddr == OFS_STAT && irqCommandsDone
        |=> regRdata[ST_DONE])
        else $error("done irq without flag");
    a_busy_commands_complete_flag_low: assert property (
        regRd && regAddr == OFS_STAT && highVoltageOn
        |=> !regRdata[ST_DONE])
        else $error("complete flag high while busy");
    a_busy_no_irq: assert property (
        highVoltageOn |-> !irqCommandsDone)
        else $error("done irq while busy");
    a_reset_quiet: assert property (
        $fell(sys_rst) |-> !highVoltageOn && !irqBuffersEmpty
        && !irqCommandsDone)
        else $error("outputs active after reset");
    a_rdata_holds: assert property (
        !regRd |=> $stable(regRdata))
        else $error("read data moved without read");
endmodule

bind ecs_sequencer ecs_seq_checker chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regRd(regRd), .regRdata(regRdata), .arrRd(arrRd),
    .arrRdata(arrRdata), .stopMode(stopMode),
    .highVoltageOn(highVoltageOn), .irqBuffersEmpty(irqBuffersEmpty),
    .irqCommandsDone(irqCommandsDone)
);

//--- sim/ecs_cpu_model.sv
// bus master model for the register and array ports
`timescale 1ns/10ps
module ecs_cpu_model
    import ecs_pkg::*;
(
    // clock
    input wire logic              sys_clk,
    // register port
    output logic [3:0]            regAddr,
    output logic [7:0]            regWdata,
    output logic                  regWr,
    output logic                  regRd,
    input wire logic [7:0]        regRdata,
    // array port
    output logic [ADDR_W-1:0]     arrAddr,
    output logic [15:0]           arrWdata,
    output logic [1:0]            arrByteEn,
    output logic                  arrWr,
    output logic                  arrRd,
    input wire logic [15:0]       arrRdata
);
    initial begin
        {regAddr, regWdata, regWr, regRd} = '0;
        {arrAddr, arrWdata, arrByteEn, arrWr, arrRd} = '0;
    end
    // released data is inverted so stale values never look valid
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge sys_clk);
        regWr    <= 1'b0;
        regWdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic awr(input logic [ADDR_W-1:0] a, input logic [15:0] d,
                       input logic [1:0] be);
        @(posedge sys_clk);
        arrAddr   <= a;
        arrWdata  <= d;
        arrByteEn <= be;
        arrWr     <= 1'b1;
        @(posedge sys_clk);
        arrWr    <= 1'b0;
        arrWdata <= ~d;
    endtask
    task automatic ard(input logic [ADDR_W-1:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        arrAddr <= a;
        arrRd   <= 1'b1;
        @(posedge sys_clk);
        arrRd <= 1'b0;
        #1 d = arrRdata;
    endtask
endmodule

//--- sim/ecs_sequencer_bench.sv
// self-checking bench for the eeprom command sequencer
`timescale 1ns/10ps
module ecs_sequencer_bench
    import ecs_pkg::*;
;
    logic              sys_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              stopMode = 1'b0;
    logic              debugState = 1'b0;
    logic              chipSecured = 1'b0;
    logic [3:0]        regAddr;
    logic [7:0]        regWdata, regRdata, r;
    logic              regWr, regRd, arrWr, arrRd;
    logic [ADDR_W-1:0] arrAddr;
    logic [15:0]       arrWdata, arrRdata, w;
    logic [1:0]        arrByteEn;
    logic              hv, irqB, irqC;
    int                errCount = 0;
    int                compares = 0;

    always #10 sys_clk = ~sys_clk;

    ecs_cpu_model cpu (.sys_clk(sys_clk), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .arrAddr(arrAddr), .arrWdata(arrWdata),
        .arrByteEn(arrByteEn), .arrWr(arrWr), .arrRd(arrRd),
        .arrRdata(arrRdata));
    ecs_sequencer dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .arrAddr(arrAddr),
        .arrWdata(arrWdata), .arrByteEn(arrByteEn), .arrWr(arrWr),
        .arrRd(arrRd), .arrRdata(arrRdata), .stopMode(stopMode),
        .debugState(debugState), .chipSecured(chipSecured),
        .highVoltageOn(hv), .irqBuffersEmpty(irqB),
        .irqCommandsDone(irqC));

    task automatic endSim();
        $display("compares %0d errors %0d", compares, errCount);
        if (errCount == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chkReg(input string n, input logic [7:0] e,
                          input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errCount++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chkWord(input string n, input logic [15:0] e,
                           input logic [15:0] g);
        compares++;
        if (g !== e) begin
            errCount++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic stat(input logic [7:0] e);
        cpu.rd(OFS_STAT, r);
        chkReg("status", e, r);
    endtask
    task automatic rdw(input logic [ADDR_W-1:0] a, input logic [15:0] e);
        cpu.ard(a, w);
        chkWord("array", e, w);
    endtask
    task automatic seq(input logic [ADDR_W-1:0] a, input logic [15:0] d,
                       input logic [7:0] c);
        cpu.awr(a, d, 2'b11);
        cpu.wr(OFS_CMD, c);
        cpu.wr(OFS_STAT, 8'h80);
    endtask
    task automatic waitDone();
        for (int i = 0; i < 200; i++) begin
            cpu.rd(OFS_STAT, r);
            if (r[ST_DONE] === 1'b1) return;
        end
        errCount++;
        $display("MISMATCH done exp 1 got 0");
        endSim();
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        cpu.awr(9'h010, 16'h1234, 2'b11);
        stat(8'hD0);
        cpu.wr(OFS_STAT, 8'h30);
        stat(8'hC0);
        cpu.wr(OFS_DIV, 8'h04);
        cpu.rd(OFS_DIV, r);
        chkReg("loaded", 8'h01, {7'h0, r[7]});
        seq(9'h000, 16'h0000, CMD_MASS);
        waitDone();
        seq(9'h000, 16'h0000, CMD_VERIFY);
        waitDone();
        stat(8'hC4);
        seq(9'h010, 16'h1234, CMD_PROG);
        rdw(9'h010, 16'hDEAD);
        stat(8'h80);
        waitDone();
        rdw(9'h010, 16'h1234);
        rdw(9'h012, ERASED);
        seq(9'h000, 16'h0000, CMD_VERIFY);
        waitDone();
        stat(8'hC0);
        seq(9'h014, 16'hABCD, CMD_PROG);
        waitDone();
        seq(9'h012, 16'h0000, CMD_SECT);
        waitDone();
        rdw(9'h010, ERASED);
        rdw(9'h014, 16'hABCD);
        // program queued behind modify fills the whole sector
        seq(9'h014, 16'h5555, CMD_MODIFY);
        seq(9'h016, 16'h6666, CMD_PROG);
        waitDone();
        rdw(9'h014, 16'h5555);
        rdw(9'h016, 16'h6666);
        for (int k = 0; k < 8; k++) begin
            cpu.awr(9'h020 | (k == 0), 16'h0000, k == 1 ? 2'b01 : 2'b11);
            case (k)
                2: cpu.awr(9'h020, 16'h0000, 2'b11);
                3: cpu.wr(OFS_CFG, 8'h00);
                4, 5: begin
                    cpu.wr(OFS_CMD, CMD_PROG);
                    cpu.wr(k == 4 ? OFS_CMD : OFS_CFG, 8'h20);
                end
                6: cpu.wr(OFS_CMD, 8'h33);
                7: cpu.wr(OFS_STAT, 8'h00);
                default: ;
            endcase
            stat(8'hD0);
            cpu.wr(OFS_STAT, 8'h80);
            stat(8'hD0);
            cpu.wr(OFS_STAT, 8'h30);
        end
        rdw(9'h020, ERASED);
        cpu.wr(OFS_PROT, 8'h00);
        for (int k = 0; k < 2; k++) begin
            cpu.awr(k ? 9'h000 : 9'h1FE, 16'h0000, 2'b11);
            cpu.wr(OFS_CMD, k ? CMD_MASS : CMD_PROG);
            cpu.wr(OFS_STAT, 8'h80);
            stat(8'hE0);
            cpu.wr(OFS_STAT, 8'h30);
        end
        cpu.wr(OFS_PROT, PROT_RST);
        cpu.rd(OFS_PROT, r);
        chkReg("prot", 8'h00, r);
        debugState <= 1'b1;
        cpu.wr(OFS_PROT, PROT_RST);
        cpu.rd(OFS_PROT, r);
        chkReg("prot", PROT_RST, r);
        // secured debug state takes only mass erase
        chipSecured <= 1'b1;
        seq(9'h018, 16'h0F0F, CMD_PROG);
        stat(8'hD0);
        cpu.wr(OFS_STAT, 8'h30);
        chipSecured <= 1'b0;
        debugState <= 1'b0;
        cpu.wr(OFS_CFG, 8'hC0);
        #1 chkReg("irq", 8'h03, {6'h0, irqB, irqC});
        seq(9'h018, 16'h0F0F, CMD_PROG);
        @(posedge sys_clk);
        #1 chkReg("irq", 8'h02, {6'h0, irqB, irqC});
        waitDone();
        cpu.wr(OFS_CFG, 8'h00);
        #1 chkReg("irq", 8'h00, {6'h0, irqB, irqC});
        seq(9'h000, 16'h0000, CMD_MASS);
        repeat (3) @(posedge sys_clk);
        stopMode <= 1'b1;
        repeat (6) @(posedge sys_clk);
        stat(8'hD0);
        stopMode <= 1'b0;
        repeat (3) @(posedge sys_clk);
        stat(8'hD0);
        cpu.wr(OFS_STAT, 8'h30);
        seq(9'h000, 16'h0000, CMD_MASS);
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b1;
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        stat(8'hC0);
        chkReg("hv", 8'h00, {7'h0, hv});
        endSim();
    end
endmodule
